// ---- als_led_model.sv ----
`timescale 1ns/10ps
module als_led_model (
   input  wire logic activeHigh,
   input  wire logic pinA,
   input  wire logic pinB,
   input  wire logic pinC,
   output logic      litA,
   output logic      litB,
   output logic      litC
);
   // =============================================================
   // Lamp state
   // =============================================================
   // lamp drive polarity
   assign litA = activeHigh ? pinA : !pinA;
   assign litB = activeHigh ? pinB : !pinB;
   assign litC = activeHigh ? pinC : !pinC;
endmodule

// ---- als_pkg.sv ----
// =============================================================
// Activity indicator constants
// =============================================================
package als_pkg;

   // =============================================================
   // Sources
   // =============================================================
   localparam int NSRC     = 5;
   localparam int SRC_PCC  = 0;
   localparam int SRC_SBUS = 1;
   localparam int SRC_MEDA = 2;
   localparam int SRC_MEDB = 3;
   localparam int SRC_MEDC = 4;

   // =============================================================
   // Timing
   // =============================================================
   localparam int CLK_MHZ       = 200;
   localparam int LONG_HOLD_MS  = 64;
   localparam int SHORT_HOLD_MS = 1;
   localparam int TEST_HOLD_NS  = 3800;
   localparam int LONG_HOLD_CYC  = LONG_HOLD_MS * 1000 * CLK_MHZ;
   localparam int SHORT_HOLD_CYC = SHORT_HOLD_MS * 1000 * CLK_MHZ;
   localparam int TEST_HOLD_CYC  = (TEST_HOLD_NS * CLK_MHZ + 999) / 1000;

   // =============================================================
   // Duration codes and output select
   // =============================================================
   typedef logic [1:0] als_dur_type;
   localparam als_dur_type DUR_LONG    = 2'h0;
   localparam als_dur_type DUR_TEST    = 2'h1;
   localparam als_dur_type DUR_THROUGH = 2'h2;
   localparam als_dur_type DUR_SHORT   = 2'h3;
   localparam logic [1:0]  SEL_SHARED  = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_TRIG, ST_HOLD} als_state_type;

   // =============================================================
   // Register map
   // =============================================================
   localparam logic [7:0] REG_MISC = 8'h00;
   localparam logic [7:0] REG_SBUS = 8'h04;
   localparam logic [7:0] REG_MEDA = 8'h08;
   localparam logic [7:0] REG_MEDB = 8'h0c;
   localparam logic [7:0] REG_MEDC = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;

   localparam int POL_BIT     = 11;
   localparam int ROUTE3_BIT  = 6;
   localparam int PCC_DUR_LSB = 12;
   localparam int SB_DUR_LSB  = 1;
   localparam int SB_SEL_LSB  = 3;
   localparam int MED_DUR_LSB = 28;
   localparam int MED_SEL_LSB = 6;
   localparam int STAT_IND_LSB  = 0;
   localparam int STAT_HOLD_LSB = 5;
   localparam int STAT_REF_BIT  = 10;

endpackage

// ---- als_stretcher.sv ----
// Behaviour
// - Indicator output rises one cycle after its source trigger rises.
// - Hold counter starts at trigger fall; default holds 64 ms then drops.
// - Trigger during hold clears counter; counting restarts at next fall.
// - Outputs active low; polarity bit 11 set makes all active high.
// - Counter on system clock; clock stop refused while any counter runs.
// - Card source duration at bits 13:12: 64 ms, test, through, 1 ms.
// - Serial bus duration at bits 2:1, same four-way coding.
// - Media A duration at bits 29:28 of its own register.
// - Media B and C have own duration fields at bits 29:28.
// - Card trigger: frame/interrupt in 32-bit mode, commands/irq in 16-bit.
// - Serial bus trigger while transmitting or receiving.
// - Media A trigger on transmit, receive and card-detect debounce.
// - Media B and C triggers while transmitting or receiving.
// - Serial bus and media join outputs A/B only when select is 11b.
// - Serial bus drives third output when route bit 6 is 0.
`timescale 1ns/10ps
module als_stretcher
   import als_pkg::*;
#(
   parameter int CNT_W          = 24,
   parameter int LONG_HOLD_CYC  = als_pkg::LONG_HOLD_CYC,
   parameter int SHORT_HOLD_CYC = als_pkg::SHORT_HOLD_CYC,
   parameter int TEST_HOLD_CYC  = als_pkg::TEST_HOLD_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        cardMode32,
   input  wire logic        cardFrameActive,
   input  wire logic        cardIntActive,
   input  wire logic        cardIoRead,
   input  wire logic        cardIoWrite,
   input  wire logic        cardOutEnable,
   input  wire logic        cardWriteEnable,
   input  wire logic        cardIntRequest,
   input  wire logic        serialBusTx,
   input  wire logic        serialBusRx,
   input  wire logic        mediaATx,
   input  wire logic        mediaARx,
   input  wire logic        mediaADebounce,
   input  wire logic        mediaBTx,
   input  wire logic        mediaBRx,
   input  wire logic        mediaCTx,
   input  wire logic        mediaCRx,
   input  wire logic        clkStopRequest,
   output logic             clkStopRefuse,
   output logic             activityOutA,
   output logic             activityOutB,
   output logic             serialBusActivityOut
);

   // =============================================================
   // Elaboration checks
   // =============================================================
   if (CNT_W < 2 || CNT_W > 30) begin : gBadWidth
      $error("CNT_W out of range");
   end
   if (LONG_HOLD_CYC < 2 || SHORT_HOLD_CYC < 2 || TEST_HOLD_CYC < 2) begin : gBadCnt
      $error("Hold counts too small");
   end
   if (LONG_HOLD_CYC >= (1 << CNT_W) || SHORT_HOLD_CYC >= (1 << CNT_W)
       || TEST_HOLD_CYC >= (1 << CNT_W)) begin : gBadFit
      $error("Hold count does not fit counter");
   end

   // =============================================================
   // Terminal count decode
   // =============================================================
   // Counts from period
   function automatic logic [CNT_W-1:0] holdLast(input als_dur_type dur);
      logic [CNT_W-1:0] last;
      last = '0;
      unique case (dur)
         DUR_LONG:    last = CNT_W'(LONG_HOLD_CYC - 1);
         DUR_SHORT:   last = CNT_W'(SHORT_HOLD_CYC - 1);
         DUR_TEST:    last = CNT_W'(TEST_HOLD_CYC - 1);
         DUR_THROUGH: last = '0;
      endcase
      return last;
   endfunction

   // =============================================================
   // Configuration registers
   // =============================================================
   logic        polarity_r;
   logic        route3Off_r;
   als_dur_type durSel_r [NSRC];
   logic [1:0]  outSel_r [NSRC];
   logic        wrStrobe;
   logic        ackNxt;

   assign ackNxt   = cyc_i & stb_i & ~ack_o;
   assign wrStrobe = ackNxt & we_i;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         polarity_r  <= 1'b0;
         route3Off_r <= 1'b0;
      end else if (wrStrobe && adr_i == REG_MISC) begin
         if (sel_i[POL_BIT / 8]) begin
            polarity_r <= dat_i[POL_BIT];
         end
         if (sel_i[ROUTE3_BIT / 8]) begin
            route3Off_r <= dat_i[ROUTE3_BIT];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NSRC; i++) begin
            durSel_r[i] <= DUR_LONG;
            outSel_r[i] <= 2'h0;
         end
      end else if (wrStrobe) begin
         unique case (adr_i)
            REG_MISC: begin
               if (sel_i[PCC_DUR_LSB / 8]) begin
                  durSel_r[SRC_PCC] <= dat_i[PCC_DUR_LSB +: 2];
               end
            end
            REG_SBUS: begin
               if (sel_i[SB_DUR_LSB / 8]) begin
                  durSel_r[SRC_SBUS] <= dat_i[SB_DUR_LSB +: 2];
                  outSel_r[SRC_SBUS] <= dat_i[SB_SEL_LSB +: 2];
               end
            end
            REG_MEDA: begin
               if (sel_i[MED_DUR_LSB / 8]) begin
                  durSel_r[SRC_MEDA] <= dat_i[MED_DUR_LSB +: 2];
               end
               if (sel_i[MED_SEL_LSB / 8]) begin
                  outSel_r[SRC_MEDA] <= dat_i[MED_SEL_LSB +: 2];
               end
            end
            REG_MEDB: begin
               if (sel_i[MED_DUR_LSB / 8]) begin
                  durSel_r[SRC_MEDB] <= dat_i[MED_DUR_LSB +: 2];
               end
               if (sel_i[MED_SEL_LSB / 8]) begin
                  outSel_r[SRC_MEDB] <= dat_i[MED_SEL_LSB +: 2];
               end
            end
            REG_MEDC: begin
               if (sel_i[MED_DUR_LSB / 8]) begin
                  durSel_r[SRC_MEDC] <= dat_i[MED_DUR_LSB +: 2];
               end
               if (sel_i[MED_SEL_LSB / 8]) begin
                  outSel_r[SRC_MEDC] <= dat_i[MED_SEL_LSB +: 2];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // =============================================================
   // Triggers
   // =============================================================
   logic [NSRC-1:0] trig;

   always_comb begin
      if (cardMode32) begin
         trig[SRC_PCC] = cardFrameActive | cardIntActive;
      end else begin
         trig[SRC_PCC] = cardIoRead | cardIoWrite | cardOutEnable
                         | cardWriteEnable | cardIntRequest;
      end
      trig[SRC_SBUS] = serialBusTx | serialBusRx;
      trig[SRC_MEDA] = mediaATx | mediaARx | mediaADebounce;
      trig[SRC_MEDB] = mediaBTx | mediaBRx;
      trig[SRC_MEDC] = mediaCTx | mediaCRx;
   end

   // =============================================================
   // Per-source stretchers
   // =============================================================
   logic [NSRC-1:0] holding;
   logic [NSRC-1:0] fallGap;
   logic [NSRC-1:0] indicator;

   for (genvar s = 0; s < NSRC; s++) begin : gSrc
      als_state_type    state_r;
      logic [CNT_W-1:0] cnt_r;

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  if (trig[s]) begin
                     state_r <= ST_TRIG;
                  end
               end
               ST_TRIG: begin
                  cnt_r <= '0;
                  if (!trig[s]) begin
                     state_r <= (durSel_r[s] == DUR_THROUGH) ? ST_IDLE : ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  if (trig[s]) begin
                     state_r <= ST_TRIG;
                     cnt_r   <= '0;
                  end else if (cnt_r >= holdLast(durSel_r[s])) begin
                     state_r <= ST_IDLE;
                     cnt_r   <= '0;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            endcase
         end
      end

      assign holding[s] = (state_r == ST_HOLD);
      assign fallGap[s] = (state_r == ST_TRIG) & (durSel_r[s] != DUR_THROUGH);
      assign indicator[s] = trig[s] | holding[s] | fallGap[s];
   end

   // =============================================================
   // Output merge
   // =============================================================
   logic [NSRC-1:0] shared;
   logic            anyShared;
   logic            thirdLevel;

   always_comb begin
      shared = '0;
      shared[SRC_PCC] = indicator[SRC_PCC];
      for (int i = 1; i < NSRC; i++) begin
         shared[i] = indicator[i] & (outSel_r[i] == SEL_SHARED);
      end
   end

   assign anyShared  = |shared;
   assign thirdLevel = indicator[SRC_SBUS] & ~route3Off_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         activityOutA         <= 1'b1;
         activityOutB         <= 1'b1;
         serialBusActivityOut <= 1'b1;
      end else begin
         activityOutA         <= polarity_r ? anyShared : ~anyShared;
         activityOutB         <= polarity_r ? anyShared : ~anyShared;
         serialBusActivityOut <= polarity_r ? thirdLevel : ~thirdLevel;
      end
   end

   // =============================================================
   // Clock stop refusal
   // =============================================================
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         clkStopRefuse <= 1'b0;
      end else begin
         clkStopRefuse <= clkStopRequest & (|holding);
      end
   end

   // =============================================================
   // Bus answer
   // =============================================================
   logic [31:0] rdData;

   always_comb begin
      rdData = 32'h0;
      unique case (adr_i)
         REG_MISC: begin
            rdData[POL_BIT]          = polarity_r;
            rdData[ROUTE3_BIT]       = route3Off_r;
            rdData[PCC_DUR_LSB +: 2] = durSel_r[SRC_PCC];
         end
         REG_SBUS: begin
            rdData[SB_DUR_LSB +: 2] = durSel_r[SRC_SBUS];
            rdData[SB_SEL_LSB +: 2] = outSel_r[SRC_SBUS];
         end
         REG_MEDA: begin
            rdData[MED_DUR_LSB +: 2] = durSel_r[SRC_MEDA];
            rdData[MED_SEL_LSB +: 2] = outSel_r[SRC_MEDA];
         end
         REG_MEDB: begin
            rdData[MED_DUR_LSB +: 2] = durSel_r[SRC_MEDB];
            rdData[MED_SEL_LSB +: 2] = outSel_r[SRC_MEDB];
         end
         REG_MEDC: begin
            rdData[MED_DUR_LSB +: 2] = durSel_r[SRC_MEDC];
            rdData[MED_SEL_LSB +: 2] = outSel_r[SRC_MEDC];
         end
         REG_STAT: begin
            rdData[STAT_IND_LSB +: NSRC]  = indicator;
            rdData[STAT_HOLD_LSB +: NSRC] = holding;
            rdData[STAT_REF_BIT]          = clkStopRefuse;
         end
         default: begin
            rdData = 32'h0;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= ackNxt;
         if (ackNxt && !we_i) begin
            dat_o <= rdData;
         end
      end
   end

endmodule

// ---- als_stretcher_checker.sv ----
`timescale 1ns/10ps
module als_stretcher_checker
   import als_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic        ack_o,
   input wire logic        cardMode32,
   input wire logic        cardFrameActive,
   input wire logic        cardIntActive,
   input wire logic        cardIoRead,
   input wire logic        cardIoWrite,
   input wire logic        cardOutEnable,
   input wire logic        cardWriteEnable,
   input wire logic        cardIntRequest,
   input wire logic        serialBusTx,
   input wire logic        clkStopRequest,
   input wire logic        clkStopRefuse,
   input wire logic        activityOutA,
   input wire logic        activityOutB,
   input wire logic        serialBusActivityOut
);
   // =============================================================
   // Tracked settings
   // =============================================================
   logic        pol_r;
   logic        route_r;
   als_dur_type dur_r;
   logic        miscWr;
   logic        cardTrig;
   assign miscWr = cyc_i && stb_i && we_i && !ack_o && adr_i == REG_MISC;
   assign cardTrig = cardMode32 ? (cardFrameActive | cardIntActive)
      : (cardIoRead | cardIoWrite | cardOutEnable | cardWriteEnable | cardIntRequest);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pol_r <= 1'b0;
         route_r <= 1'b0;
         dur_r <= DUR_LONG;
      end else if (miscWr) begin
         if (sel_i[1]) begin
            pol_r <= dat_i[POL_BIT];
            dur_r <= dat_i[PCC_DUR_LSB +: 2];
         end
         if (sel_i[0]) begin
            route_r <= dat_i[ROUTE3_BIT];
         end
      end
   end
   // =============================================================
   // Properties
   // =============================================================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_ack_next;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ab_equal;
      activityOutA == activityOutB;
   endproperty
   a_ab_equal: assert property (p_ab_equal) else $error("shared outputs differ");
   property p_refuse_req;
      clkStopRefuse |-> $past(clkStopRequest);
   endproperty
   a_refuse_req: assert property (p_refuse_req) else $error("refusal without request");
   property p_card_rise;
      cardTrig && !miscWr |=> activityOutA == pol_r;
   endproperty
   a_card_rise: assert property (p_card_rise) else $error("card indicator late");
   property p_sbus_third;
      serialBusTx && !route_r && !miscWr |=> serialBusActivityOut == pol_r;
   endproperty
   a_sbus_third: assert property (p_sbus_third) else $error("third output idle");
   property p_refuse_hold;
      cardTrig ##1 (!cardTrig && clkStopRequest && dur_r != DUR_THROUGH && !miscWr) [*2]
         |=> clkStopRefuse;
   endproperty
   a_refuse_hold: assert property (p_refuse_hold) else $error("stop not refused");
   property p_test_hold;
      $fell(cardTrig) && dur_r == DUR_TEST && !miscWr |-> (activityOutA == pol_r) [*8];
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("test hold too short");
endmodule

bind als_stretcher als_stretcher_checker u_chk (.clock, .rst, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .ack_o, .cardMode32, .cardFrameActive, .cardIntActive,
   .cardIoRead, .cardIoWrite, .cardOutEnable, .cardWriteEnable, .cardIntRequest,
   .serialBusTx, .clkStopRequest, .clkStopRefuse, .activityOutA, .activityOutB,
   .serialBusActivityOut);

// ---- als_stretcher_tb.sv ----
`timescale 1ns/10ps
module als_stretcher_tb
   import als_pkg::*;
;
   localparam int LH = 40;
   localparam int SH = 20;
   localparam int TH = 10;
   localparam logic [7:0] REGS [5] = '{REG_MISC, REG_SBUS, REG_MEDA, REG_MEDB, REG_MEDC};
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat, rd;
   logic        ack, refuse, pinA, pinB, pinC, litA, litB, litC;
   logic        mode = 1'b1;
   logic        req = 1'b0;
   logic        pol = 1'b0;
   logic [15:0] trig = 16'h0;
   int          errTotal = 0;
   int          checks = 0;
   always #2.5 clock = ~clock;
   als_stretcher #(.LONG_HOLD_CYC(LH), .SHORT_HOLD_CYC(SH), .TEST_HOLD_CYC(TH)) dut (
      .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .cardMode32(mode),
      .cardFrameActive(trig[0]), .cardIntActive(trig[1]), .cardIoRead(trig[2]),
      .cardIoWrite(trig[3]), .cardOutEnable(trig[4]), .cardWriteEnable(trig[5]),
      .cardIntRequest(trig[6]), .serialBusTx(trig[7]), .serialBusRx(trig[8]),
      .mediaATx(trig[9]), .mediaARx(trig[10]), .mediaADebounce(trig[11]),
      .mediaBTx(trig[12]), .mediaBRx(trig[13]), .mediaCTx(trig[14]), .mediaCRx(trig[15]),
      .clkStopRequest(req), .clkStopRefuse(refuse), .activityOutA(pinA),
      .activityOutB(pinB), .serialBusActivityOut(pinC));
   als_led_model led (.activeHigh(pol), .pinA(pinA), .pinB(pinB), .pinC(pinC),
      .litA(litA), .litB(litB), .litC(litC));
   // =============================================================
   // Tasks
   // =============================================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errTotal++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic w);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic int holdOf(input als_dur_type c);
      case (c)
         DUR_LONG: return LH;
         DUR_SHORT: return SH;
         DUR_TEST: return TH;
         default: return 0;
      endcase
   endfunction
   task automatic setDur(input int s, input als_dur_type c);
      logic [31:0] d;
      d = (s == 0) ? 32'(c) << PCC_DUR_LSB | 32'(pol) << POL_BIT
        : (s == 1) ? 32'(c) << SB_DUR_LSB | 32'h18 : 32'(c) << MED_DUR_LSB | 32'hc0;
      wb(REGS[s], d, (s == 0) ? 4'h2 : (s == 1) ? 4'h1 : 4'h9, 1'b1);
      wb(REGS[s], 32'h0, 4'hf, 1'b0);
      chk("duration register", d, rd);
   endtask
   task automatic pulse(input int i, input int n, input logic eA, input logic eC,
                        input logic rt);
      @(posedge clock);
      trig[i] <= 1'b1;
      @(posedge clock);
      #1 chk("shared indicator", eA, litA);
      chk("second shared indicator", eA, litB);
      chk("serial bus indicator", eC, litC);
      @(posedge clock);
      trig[i] <= 1'b0;
      @(posedge clock);
      #1 chk("indicator after fall", eA && n > 0, litA);
      if (rt) begin
         repeat (n / 2) @(posedge clock);
         trig[i] <= 1'b1;
         @(posedge clock);
         trig[i] <= 1'b0;
         repeat (n + 1) @(posedge clock);
      end else begin
         repeat (n) @(posedge clock);
      end
      #1 if (n > 0) chk("held indicator", eA, litA);
      chk("clock stop refusal", req && n > 0, refuse);
      @(posedge clock);
      #1 chk("released indicators", 0, litA | litB | litC);
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // =============================================================
   // Tests
   // =============================================================
   initial begin
      int s;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      wb(REG_STAT, 32'hffffffff, 4'hf, 1'b1);
      wb(8'h18, 32'hffffffff, 4'hf, 1'b1);
      wb(REG_MISC, 32'hffffffff, 4'h0, 1'b1);
      for (int k = 0; k < 7; k++) begin
         wb(8'(4 * k), 32'h0, 4'hf, 1'b0);
         chk("register reset or refused write", 0, rd);
      end
      chk("idle pins", 3'h7, {pinA, pinB, pinC});
      req <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         s = i < 7 ? 0 : i < 9 ? 1 : i < 12 ? 2 : i < 14 ? 3 : 4;
         @(posedge clock);
         mode <= i < 2;
         for (int c = 0; c < 4; c++) begin
            setDur(s, als_dur_type'(c));
            pulse(i, holdOf(als_dur_type'(c)), 1'b1, s == 1, c == 0);
         end
      end
      @(posedge clock);
      mode <= 1'b1;
      setDur(0, DUR_THROUGH);
      pulse(2, 0, 1'b0, 1'b0, 1'b0);
      wb(REG_SBUS, 32'h0c, 4'h1, 1'b1);
      pulse(7, 0, 1'b0, 1'b1, 1'b0);
      wb(REG_MEDA, 32'h20000000, 4'h9, 1'b1);
      pulse(9, 0, 1'b0, 1'b0, 1'b0);
      wb(REG_MISC, 32'h40, 4'h1, 1'b1);
      pulse(7, 0, 1'b0, 1'b0, 1'b0);
      wb(REG_MISC, 32'h0, 4'h1, 1'b1);
      req <= 1'b0;
      setDur(0, DUR_SHORT);
      pulse(0, SH, 1'b1, 1'b0, 1'b1);
      pol = 1'b1;
      setDur(0, DUR_TEST);
      chk("idle pins active high", 0, {pinA, pinB, pinC});
      pulse(0, TH, 1'b1, 1'b0, 1'b0);
      results();
   end
   initial begin
      repeat (20000) @(posedge clock);
      errTotal++;
      results();
   end
endmodule
